// ==== hw/adc_control_and_result_regs.sv ====
/*
 * control, status and result registers of a 10-bit sar converter, axi4-lite slave.
 * assumes the analog core runs on ref_clk and holds coreResult steady in the store cycle
 * right after coreCtrl.active falls; lowPowerEntry is a one-cycle pulse from power logic.
 */
// The AXI4-Lite slave port was chosen for this implementation.
module adc_control_and_result_regs (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic lowPowerEntry, // halt, idle or slow mode entered
	input wire logic [9:0] coreResult, // sar result from analog core
	output adc_ctrl_pkg::core_ctrl_t coreCtrl,
	output logic convDoneIrq, // one-cycle conversion done request
	input wire logic awvalid,
	output logic awready,
	input wire logic [adc_ctrl_pkg::ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [adc_ctrl_pkg::ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp
);
	// ************************************************************
	// bus slave state
	// ************************************************************
	logic awHeld_ff; // write address taken, not yet used
	logic wHeld_ff; // write data taken, not yet used
	logic [adc_ctrl_pkg::ADDR_W-1:0] awAddr_ff;
	logic [7:0] wData_ff; // only the low lane carries register bits
	logic wLane_ff; // low byte strobe
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [7:0] rdata_ff;
	logic [1:0] rresp_ff;

	// ************************************************************
	// converter state
	// ************************************************************
	logic startBit_ff;
	adc_ctrl_pkg::op_mode_t mode_ff;
	logic gate_ff;
	logic [3:0] chan_ff;
	logic [2:0] time_ff;
	logic done_ff;
	logic pairOpen_ff; // low byte read, high byte not yet
	logic [9:0] result_ff;
	logic irq_ff;
	adc_ctrl_pkg::conv_state_t state_ff, nxtState;
	logic [9:0] cnt_ff, nxtCnt; // remaining convert cycles

	// ************************************************************
	// decode
	// ************************************************************
	wire writeFire = awHeld_ff & wHeld_ff; // both halves present
	wire adc_ctrl_pkg::reg_sel_t wrSel = adc_ctrl_pkg::regDecode(awAddr_ff);
	wire adc_ctrl_pkg::reg_sel_t rdSel = adc_ctrl_pkg::regDecode(araddr);
	wire arHs = arvalid & arready;
	wire wrCtrlOne = writeFire & wLane_ff & (wrSel == adc_ctrl_pkg::SEL_CTRL_ONE);
	wire wrCtrlTwo = writeFire & wLane_ff & (wrSel == adc_ctrl_pkg::SEL_CTRL_TWO);
	wire [1:0] wrMode = wData_ff[adc_ctrl_pkg::C1_MODE_HI:adc_ctrl_pkg::C1_MODE_LO];
	// forced stop by software
	wire modeStopWr = wrCtrlOne & (wrMode == adc_ctrl_pkg::MODE_OFF);
	// forced stop from either source
	wire kill = lowPowerEntry | modeStopWr;
	wire rdHigh = arHs & (rdSel == adc_ctrl_pkg::SEL_RES_HIGH);
	wire rdLow = arHs & (rdSel == adc_ctrl_pkg::SEL_RES_LOW);
	wire busy = (state_ff != adc_ctrl_pkg::ST_IDLE);
	wire modeRun = (mode_ff == adc_ctrl_pkg::MODE_SINGLE) ||
		(mode_ff == adc_ctrl_pkg::MODE_REPEAT);
	wire isIdle = (state_ff == adc_ctrl_pkg::ST_IDLE);
	wire isLaunch = (state_ff == adc_ctrl_pkg::ST_LAUNCH);
	wire isStore = (state_ff == adc_ctrl_pkg::ST_STORE);
	// a result landing inside an open read pair is dropped
	wire storeOk = isStore & ~pairOpen_ff & ~kill;
	wire singleRestart = isLaunch & (mode_ff == adc_ctrl_pkg::MODE_SINGLE);
	wire [9:0] loadCnt = adc_ctrl_pkg::convCycles(time_ff) - 10'h001;

	// read views; reserved bits are zero
	wire [7:0] viewOne = {startBit_ff, mode_ff, gate_ff, chan_ff};
	wire [7:0] viewTwo = {done_ff, busy, 3'h0, time_ff};
	wire [7:0] viewLow = result_ff[7:0];
	wire [7:0] viewHigh = {6'h00, result_ff[9:8]};
	wire [7:0] rdMux = (rdSel == adc_ctrl_pkg::SEL_CTRL_ONE) ? viewOne :
		(rdSel == adc_ctrl_pkg::SEL_CTRL_TWO) ? viewTwo :
		(rdSel == adc_ctrl_pkg::SEL_RES_LOW) ? viewLow :
		(rdSel == adc_ctrl_pkg::SEL_RES_HIGH) ? viewHigh : 8'h00;

	// ************************************************************
	// bus handshakes
	// ************************************************************
	// no new write taken until the response is gone: one write at a time
	assign awready = ~awHeld_ff & ~bvalid_ff;
	assign wready = ~wHeld_ff & ~bvalid_ff;
	assign arready = ~rvalid_ff;
	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign rvalid = rvalid_ff;
	assign rdata = {24'h000000, rdata_ff};
	assign rresp = rresp_ff;

	// write address and data may arrive in either order
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			awHeld_ff <= 1'b0;
			awAddr_ff <= '0;
		end else if (awvalid & awready) begin
			awHeld_ff <= 1'b1;
			awAddr_ff <= awaddr;
		end else if (writeFire) begin
			awHeld_ff <= 1'b0;
		end
	end

	// write data holder, low lane only
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wHeld_ff <= 1'b0;
			wData_ff <= adc_ctrl_pkg::RESET_BYTE;
			wLane_ff <= 1'b0;
		end else if (wvalid & wready) begin
			wHeld_ff <= 1'b1;
			wData_ff <= wdata[7:0];
			wLane_ff <= wstrb[0];
		end else if (writeFire) begin
			wHeld_ff <= 1'b0;
		end
	end

	// write response; unmapped addresses answer slverr
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= adc_ctrl_pkg::RESP_OKAY;
		end else if (writeFire) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= (wrSel == adc_ctrl_pkg::SEL_NONE) ?
				adc_ctrl_pkg::RESP_SLVERR : adc_ctrl_pkg::RESP_OKAY;
		end else if (bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// read answer one cycle after the address is taken
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= adc_ctrl_pkg::RESET_BYTE;
			rresp_ff <= adc_ctrl_pkg::RESP_OKAY;
		end else if (arHs) begin
			rvalid_ff <= 1'b1;
			rdata_ff <= rdMux;
			rresp_ff <= (rdSel == adc_ctrl_pkg::SEL_NONE) ?
				adc_ctrl_pkg::RESP_SLVERR : adc_ctrl_pkg::RESP_OKAY;
		end else if (rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// ************************************************************
	// conversion sequencer
	// ************************************************************
	// launch and store take one cycle each, well inside the latency bound
	always_comb begin
		nxtState = state_ff;
		nxtCnt = cnt_ff;
		unique case (state_ff)
			adc_ctrl_pkg::ST_IDLE: begin
				if (startBit_ff && modeRun) begin
					nxtState = adc_ctrl_pkg::ST_LAUNCH;
				end
			end
			adc_ctrl_pkg::ST_LAUNCH: begin
				nxtState = adc_ctrl_pkg::ST_CONVERT;
				nxtCnt = loadCnt;
			end
			adc_ctrl_pkg::ST_CONVERT: begin
				if (cnt_ff == 10'h000) begin
					nxtState = adc_ctrl_pkg::ST_STORE;
				end else begin
					nxtCnt = cnt_ff - 10'h001;
				end
			end
			adc_ctrl_pkg::ST_STORE: begin
				// repeat goes straight into the next run
				if (mode_ff == adc_ctrl_pkg::MODE_REPEAT) begin
					nxtState = adc_ctrl_pkg::ST_CONVERT;
					nxtCnt = loadCnt;
				end else begin
					nxtState = adc_ctrl_pkg::ST_IDLE;
				end
			end
		endcase
		// forced stop leaves at once without a store
		if (kill) begin
			nxtState = adc_ctrl_pkg::ST_IDLE;
		end
	end

	// sequencer registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_ff <= adc_ctrl_pkg::ST_IDLE;
			cnt_ff <= 10'h000;
		end else begin
			state_ff <= nxtState;
			cnt_ff <= nxtCnt;
		end
	end

	// ************************************************************
	// control register one
	// ************************************************************
	// start only accepted when idle; a start while busy is dropped
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			startBit_ff <= 1'b0;
		end else if (kill) begin
			startBit_ff <= 1'b0;
		end else if (wrCtrlOne && isIdle) begin
			startBit_ff <= wData_ff[adc_ctrl_pkg::C1_START];
		end else if (isLaunch || (isIdle && !modeRun)) begin
			startBit_ff <= 1'b0;
		end
	end

	// mode and gate, both cleared by low-power entry
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mode_ff <= adc_ctrl_pkg::MODE_OFF;
			gate_ff <= 1'b0;
		end else if (lowPowerEntry) begin
			mode_ff <= adc_ctrl_pkg::MODE_OFF;
			gate_ff <= 1'b0;
		end else if (wrCtrlOne) begin
			mode_ff <= adc_ctrl_pkg::op_mode_t'(wrMode);
			gate_ff <= wData_ff[adc_ctrl_pkg::C1_GATE];
		end
	end

	// channel and time code keep their values through low-power entry
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			chan_ff <= 4'h0;
			time_ff <= 3'h0;
		end else begin
			if (wrCtrlOne) begin
				chan_ff <= wData_ff[adc_ctrl_pkg::C1_CHAN_HI:0];
			end
			// bits 7 to 3 of the written byte are dropped
			if (wrCtrlTwo) begin
				time_ff <= wData_ff[adc_ctrl_pkg::C2_TIME_HI:0];
			end
		end
	end

	// ************************************************************
	// status and results
	// ************************************************************
	// a store beats a clear in the same cycle; a forced stop beats both
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			done_ff <= 1'b0;
		end else if (kill) begin
			done_ff <= 1'b0;
		end else if (storeOk) begin
			done_ff <= 1'b1;
		end else if (rdHigh || singleRestart) begin
			done_ff <= 1'b0;
		end
	end

	// open read pair tracking
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pairOpen_ff <= 1'b0;
		end else if (kill || rdHigh) begin
			pairOpen_ff <= 1'b0;
		end else if (rdLow) begin
			pairOpen_ff <= 1'b1;
		end
	end

	// result store and done request
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			result_ff <= 10'h000;
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= storeOk;
			if (kill) begin
				result_ff <= 10'h000;
			end else if (storeOk) begin
				result_ff <= coreResult;
			end
		end
	end

	// ************************************************************
	// analog core drive
	// ************************************************************
	assign coreCtrl = '{sample: isLaunch, active: (state_ff == adc_ctrl_pkg::ST_CONVERT),
		gate: gate_ff, chan: chan_ff};
	assign convDoneIrq = irq_ff;

	// ************************************************************
	// checks
	// ************************************************************
	logic [9:0] convLen_ff; // helper: cycles spent converting
	always_ff @(posedge ref_clk) begin
		if (rst || (state_ff != adc_ctrl_pkg::ST_CONVERT)) begin
			convLen_ff <= 10'h000;
		end else begin
			convLen_ff <= convLen_ff + 10'h001;
		end
	end

	sequence s_stopWrite;
		modeStopWr;
	endsequence
	sequence s_allClear;
		isIdle && !done_ff && (result_ff == 10'h000) && !startBit_ff;
	endsequence

	a_start_clears: assert property (@(posedge ref_clk) disable iff (rst)
		isLaunch && !kill |=> !startBit_ff && coreCtrl.active)
		else $error("start bit not cleared after launch");
	a_mode_stop: assert property (@(posedge ref_clk) disable iff (rst)
		s_stopWrite |=> s_allClear ##1 !convDoneIrq)
		else $error("mode off write did not stop and clear");
	a_lowpower_clear: assert property (@(posedge ref_clk) disable iff (rst)
		lowPowerEntry |=> mode_ff == adc_ctrl_pkg::MODE_OFF && !gate_ff && !busy
			&& !done_ff && result_ff == 10'h000)
		else $error("low power entry left state set");
	a_conv_length: assert property (@(posedge ref_clk) disable iff (rst)
		state_ff == adc_ctrl_pkg::ST_CONVERT && cnt_ff == 10'h000 && $stable(time_ff)
		|-> convLen_ff == adc_ctrl_pkg::convCycles(time_ff) - 10'h001)
		else $error("conversion length wrong for time code");
	a_done_store: assert property (@(posedge ref_clk) disable iff (rst)
		isStore && !pairOpen_ff && !kill |=> done_ff && convDoneIrq
			&& result_ff == $past(coreResult))
		else $error("completion did not store and flag");
	a_pair_discard: assert property (@(posedge ref_clk) disable iff (rst)
		isStore && pairOpen_ff && !kill |=> !convDoneIrq && $stable(result_ff))
		else $error("result overwritten inside read pair");
	a_high_clear: assert property (@(posedge ref_clk) disable iff (rst)
		rdHigh && !storeOk |=> !done_ff && rvalid)
		else $error("high byte read did not clear done");
	a_repeat_next: assert property (@(posedge ref_clk) disable iff (rst)
		isStore && mode_ff == adc_ctrl_pkg::MODE_REPEAT && !kill
		|=> coreCtrl.active && busy && $stable(chan_ff))
		else $error("repeat mode did not restart");
	a_busy_span: assert property (@(posedge ref_clk) disable iff (rst)
		isIdle && startBit_ff && modeRun && !kill |=> busy ##1 (busy || $past(kill)))
		else $error("busy not set at start");
	a_status_zero: assert property (@(posedge ref_clk) disable iff (rst)
		arHs && rdSel == adc_ctrl_pkg::SEL_CTRL_TWO |=> rvalid && rdata[5:3] == 3'h0
			&& rdata[6] == $past(busy))
		else $error("status read shows reserved bits or stale busy");
endmodule

// ==== hw/adc_ctrl_pkg.sv ====
/*
 * shared constants and types for the converter control and result registers.
 * assumes a 32-bit axi4-lite master and a sar analog core on the same clock.
 */
package adc_ctrl_pkg;
	// ************************************************************
	// register map
	// ************************************************************
	localparam int ADDR_W = 12; // byte address width seen by the slave
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CTRL_ONE = 8'h34;
	localparam logic [7:0] IDX_CTRL_TWO = 8'h35;
	localparam logic [7:0] IDX_RES_LOW = 8'h36;
	localparam logic [7:0] IDX_RES_HIGH = 8'h37;
	localparam logic [ADDR_W-1:0] ADDR_CTRL_ONE = {2'h0, IDX_CTRL_ONE, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_CTRL_TWO = {2'h0, IDX_CTRL_TWO, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_RES_LOW = {2'h0, IDX_RES_LOW, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_RES_HIGH = {2'h0, IDX_RES_HIGH, 2'h0};
	localparam logic [7:0] RESET_BYTE = 8'h00; // every register resets to zero

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int C1_START = 7; // conv_start_bit
	localparam int C1_MODE_HI = 6; // op_mode_sel
	localparam int C1_MODE_LO = 5;
	localparam int C1_GATE = 4; // analog_in_gate
	localparam int C1_CHAN_HI = 3; // chan_select, down to bit 0
	localparam int C2_TIME_HI = 2; // conversion time code, down to bit 0

	// ************************************************************
	// codes and timing
	// ************************************************************
	typedef enum logic [1:0] {
		MODE_OFF = 2'b00,
		MODE_SINGLE = 2'b01,
		MODE_RSVD = 2'b10,
		MODE_REPEAT = 2'b11
	} op_mode_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LAUNCH = 2'b01,
		ST_CONVERT = 2'b10,
		ST_STORE = 2'b11
	} conv_state_t;
	typedef enum logic [2:0] {
		SEL_NONE = 3'b000,
		SEL_CTRL_ONE = 3'b001,
		SEL_CTRL_TWO = 3'b010,
		SEL_RES_LOW = 3'b011,
		SEL_RES_HIGH = 3'b100
	} reg_sel_t;
	// conversion lengths in oscillator periods: 39, 78, 156, 312, 624
	localparam logic [9:0] CYC_T0 = 10'h027;
	localparam logic [9:0] CYC_T1 = 10'h04e;
	localparam logic [9:0] CYC_T2 = 10'h09c;
	localparam logic [9:0] CYC_T3 = 10'h138;
	localparam logic [9:0] CYC_T4 = 10'h270;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// signals toward the analog core
	typedef struct packed {
		logic sample; // one-cycle sample-hold strobe
		logic active; // comparator sequence running
		logic gate; // analog inputs enabled
		logic [3:0] chan; // selected input
	} core_ctrl_t;

	// time code to cycle count; reserved codes fall back to the longest
	function automatic logic [9:0] convCycles(input logic [2:0] code);
		unique case (code)
			3'h0: convCycles = CYC_T0;
			3'h1: convCycles = CYC_T1;
			3'h2: convCycles = CYC_T2;
			3'h3: convCycles = CYC_T3;
			default: convCycles = CYC_T4;
		endcase
	endfunction

	// byte address to register select
	function automatic reg_sel_t regDecode(input logic [ADDR_W-1:0] addr);
		unique case (addr)
			ADDR_CTRL_ONE: regDecode = SEL_CTRL_ONE;
			ADDR_CTRL_TWO: regDecode = SEL_CTRL_TWO;
			ADDR_RES_LOW: regDecode = SEL_RES_LOW;
			ADDR_RES_HIGH: regDecode = SEL_RES_HIGH;
			default: regDecode = SEL_NONE;
		endcase
	endfunction
endpackage

// ==== test/sar_core_model.sv ====
/*
 * behavioural sar analog core facing the converter control block.
 * assumes it shares ref_clk with the block and that coreCtrl is decoded from its state.
 */
module sar_core_model (
	input wire logic ref_clk,
	input wire adc_ctrl_pkg::core_ctrl_t coreCtrl,
	output logic [9:0] coreResult,
	output logic [9:0] prevResult
);
	timeunit 1ns;
	timeprecision 1ns;
	// ************************************************************
	// conversion value source
	// ************************************************************
	logic activeDly = 1'b0; // active, one cycle late
	logic [5:0] seqCnt = 6'h00; // counts conversions so results differ
	logic [9:0] value = 10'h3ff; // value presented to the block
	initial prevResult = 10'h000;
	// a fresh value at each rising active, kept through the store cycle
	always @(posedge ref_clk) begin
		activeDly <= coreCtrl.active;
		if (coreCtrl.active && !activeDly) begin
			seqCnt <= seqCnt + 6'h01;
			// disabled inputs convert as zero
			value <= coreCtrl.gate ? {1'b1, coreCtrl.chan[2:0], seqCnt} : 10'h000;
		end
		// what the block should have captured at this edge
		if (activeDly && !coreCtrl.active) begin
			prevResult <= value;
		end
	end
	// outside the hold span the line shows the inverse, never a stale copy
	assign coreResult = (coreCtrl.active || activeDly) ? value : ~value;
endmodule

// ==== test/tb_adc_control_and_result_regs.sv ====
/*
 * self-checking bench for the converter control and result registers.
 * assumes the sar core model and an axi4-lite master on one 100 mhz clock.
 */
module tb_adc_control_and_result_regs;
	timeunit 1ns;
	timeprecision 1ns;
	// ************************************************************
	// signals
	// ************************************************************
	localparam logic [11:0] A1 = adc_ctrl_pkg::ADDR_CTRL_ONE;
	localparam logic [11:0] A2 = adc_ctrl_pkg::ADDR_CTRL_TWO;
	localparam logic [11:0] A3 = adc_ctrl_pkg::ADDR_RES_LOW;
	localparam logic [11:0] A4 = adc_ctrl_pkg::ADDR_RES_HIGH;
	localparam logic [1:0] OK = adc_ctrl_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = adc_ctrl_pkg::RESP_SLVERR;
	logic ref_clk = 1'b0, rst = 1'b1, lowPowerEntry = 1'b0;
	logic [9:0] coreResult, prevResult;
	adc_ctrl_pkg::core_ctrl_t coreCtrl;
	logic convDoneIrq, awready, wready, bvalid, arready, rvalid;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic bready = 1'b1, rready = 1'b1; // always ready for answers
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h00000000, rdata;
	logic [3:0] wstrb = 4'h1; // only byte lane zero carries a register
	logic [1:0] bresp, rresp;
	int fails = 0, n_compared = 0;
	adc_control_and_result_regs adc_control_and_result_regs_inst (
		.ref_clk(ref_clk), .rst(rst), .lowPowerEntry(lowPowerEntry),
		.coreResult(coreResult), .coreCtrl(coreCtrl), .convDoneIrq(convDoneIrq),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
		.wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
	sar_core_model sar_core_model_inst (.ref_clk(ref_clk), .coreCtrl(coreCtrl),
		.coreResult(coreResult), .prevResult(prevResult));
	initial forever #5 ref_clk = ~ref_clk;
	// ************************************************************
	// compare and bus tasks
	// ************************************************************
	task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
		end
	endtask
	task automatic chkResp(input logic [1:0] got, input logic [1:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: response %h, wanted %h", $time, got, exp);
		end
	endtask
	task automatic chkRange(input int n, input int lo, input int hi);
		n_compared++;
		if (n < lo || n > hi) begin
			fails++;
			$display("unexpected at %0t: %0d cycles, wanted %0d to %0d", $time, n, lo, hi);
		end
	endtask
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		logic done;
		done = 1'b0;
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!done) begin
			@(posedge ref_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				done = 1'b1;
				chkResp(bresp, er);
			end
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
		logic done;
		done = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		while (!done) begin
			@(posedge ref_clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				done = 1'b1;
				chkVal(rdata, exp);
				chkResp(rresp, er);
			end
		end
	endtask
	// edges until the done request; lim + 1 when it never came
	task automatic waitIrq(input int lim, output int n);
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (convDoneIrq !== 1'b1 && n < lim);
		if (convDoneIrq !== 1'b1) n = lim + 1;
	endtask
	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic testRegs();
		for (int i = 0; i < 4; i++) rd(A1 + 12'(4 * i), 32'h0, OK);
		rd(12'h000, 32'h0, ERR);
		wr(12'h0e0, 8'hff, ERR);
		wr(A2, 8'hf7, OK);
		rd(A2, 32'h07, OK);
		wr(A3, 8'h5a, OK);
		rd(A3, 32'h0, OK);
		wr(A1, 8'hc7, OK); // reserved mode with start
		rd(A1, 32'h47, OK);
		rd(A2, 32'h07, OK);
		wr(A1, 8'h1c, OK);
		chkVal({31'h0, coreCtrl.gate}, 32'h1);
		chkVal({28'h0, coreCtrl.chan}, 32'hc);
		wr(A1, 8'h0c, OK);
		chkVal({31'h0, coreCtrl.gate}, 32'h0);
	endtask
	task automatic testSingle();
		int n;
		int base[5] = '{39, 78, 156, 312, 624};
		int extra[5] = '{10, 10, 32, 32, 128};
		for (int c = 0; c < 5; c++) begin
			wr(A2, 8'(c), OK);
			wr(A1, 8'h30 | 8'(c), OK);
			wr(A1, 8'hb0 | 8'(c), OK);
			waitIrq(900, n);
			chkRange(n, base[c], base[c] + extra[c]);
			chkVal({28'h0, coreCtrl.chan}, 32'(c));
			rd(A1, 32'h30 | 32'(c), OK);
			rd(A2, 32'h80 | 32'(c), OK);
			rd(A3, {24'h0, prevResult[7:0]}, OK);
			rd(A4, {30'h0, prevResult[9:8]}, OK);
			rd(A2, 32'(c), OK);
		end
	endtask
	task automatic testRepeat();
		int n;
		logic [9:0] kept;
		wr(A2, 8'h00, OK);
		wr(A1, 8'h75, OK);
		wr(A1, 8'hf5, OK);
		waitIrq(100, n);
		chkRange(n, 39, 49);
		waitIrq(100, n);
		chkRange(n, 39, 49);
		kept = prevResult;
		rd(A2, 32'hc0, OK);
		rd(A3, {24'h0, kept[7:0]}, OK);
		// stores inside the open pair must stay silent
		waitIrq(100, n);
		chkRange(n, 101, 101);
		rd(A4, {30'h0, kept[9:8]}, OK);
		wr(A1, 8'h15, OK); // stop mid-run
		rd(A2, 32'h00, OK);
		rd(A3, 32'h0, OK);
		rd(A4, 32'h0, OK);
		waitIrq(60, n);
		chkRange(n, 61, 61);
		chkVal({31'h0, coreCtrl.active}, 32'h0);
	endtask
	task automatic testLowPower();
		int n;
		wr(A2, 8'h04, OK);
		wr(A1, 8'h32, OK);
		wr(A1, 8'hb2, OK);
		waitIrq(900, n);
		chkRange(n, 624, 752);
		wr(A1, 8'hb2, OK); // restart, high byte left unread
		// launch cycle: done clears at its end, so look one edge later
		@(posedge ref_clk);
		chkVal({31'h0, coreCtrl.sample}, 32'h1);
		rd(A2, 32'h44, OK);
		lowPowerEntry <= 1'b1;
		@(posedge ref_clk);
		lowPowerEntry <= 1'b0;
		rd(A1, 32'h02, OK);
		rd(A2, 32'h04, OK);
		rd(A3, 32'h0, OK);
		rd(A4, 32'h0, OK);
		chkVal({31'h0, coreCtrl.gate}, 32'h0);
	endtask
	// ************************************************************
	// sequence and verdict
	// ************************************************************
	task automatic final_report();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// reset for six cycles, then one quiet edge before the first request
	initial begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		testRegs();
		testSingle();
		testRepeat();
		testLowPower();
		final_report();
	end
	// the whole sequence needs a few thousand cycles; far more means a hang
	initial begin
		#200000;
		fails++;
		final_report();
	end
endmodule
